// ---- rtl/eppr_pkg.sv ----
// Shared constants and types of the page permission restriction engine.
// Assumes one core clock domain; no other file defines these names.
package eppr_pkg;

  // ************************************************************
  // Leaf selection and privilege
  // ************************************************************
  localparam int          LEAF_W             = 32;
  localparam logic [31:0] RESTRICT_LEAF_CODE = 32'h0000_000E;
  localparam int          CPL_W              = 2;
  localparam logic [1:0]  KERNEL_CPL         = 2'h0;

  // ************************************************************
  // Alignment and descriptor layout
  // ************************************************************
  localparam int DESC_ALIGN_BITS = 6;
  localparam int PAGE_ALIGN_BITS = 12;
  localparam int DESC_W          = 512;
  localparam int FLAG_R_POS      = 0;
  localparam int FLAG_W_POS      = 1;
  localparam int FLAG_X_POS      = 2;
  localparam int DESC_RSVD_LSB   = 16;

  // ************************************************************
  // Page metadata
  // ************************************************************
  localparam int         PAGE_TYPE_W       = 8;
  localparam logic [7:0] REGULAR_PAGE_TYPE = 8'h01;
  localparam int         RWX_W             = 3;

  // Bit positions of the leaf activity vector for the target page.
  localparam int LEAF_VEC_W         = 9;
  localparam int LV_ACCEPT_CHANGE   = 0;
  localparam int LV_ACCEPT_COPY     = 1;
  localparam int LV_EXTEND_PERM     = 2;
  localparam int LV_RESTRICT_PERM   = 3;
  localparam int LV_CHANGE_TYPE     = 4;
  localparam int LV_ADD_PAGE        = 5;
  localparam int LV_MEASURE_EXTEND  = 6;
  localparam int LV_INITIALIZE      = 7;
  localparam int LV_TRACK           = 8;
  localparam logic [8:0] EXCLUSIVE_LEAF_MASK = 9'h01F;

  // ************************************************************
  // Result register codes
  // ************************************************************
  localparam int          RESULT_W                 = 64;
  localparam logic [63:0] RESULT_OK                = 64'h0000_0000_0000_0000;
  localparam logic [63:0] PAGE_NOT_MODIFIABLE_CODE = 64'h0000_0000_0000_0001;
  localparam logic [63:0] PAGE_CONFLICT_CODE       = 64'h0000_0000_0000_0002;

  // ************************************************************
  // Sequencer states and outcomes
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DESC   = 3'b001,
    ST_META   = 3'b010,
    ST_OWNER  = 3'b011,
    ST_MARK   = 3'b100,
    ST_UPDATE = 3'b101
  } eppr_state_t;

  typedef enum logic [2:0] {
    OUT_NONE     = 3'b000,
    OUT_OK       = 3'b001,
    OUT_GP       = 3'b010,
    OUT_PF       = 3'b011,
    OUT_CONFLICT = 3'b100,
    OUT_NOTMOD   = 3'b101
  } eppr_outcome_t;

endpackage : eppr_pkg

// ---- rtl/eppr_rst_sync.sv ----
// Reset release synchroniser for the core clock domain.
// Assumes an active low asynchronous reset at its input.
`timescale 1ns/1ps
`default_nettype none
module eppr_rst_sync (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output logic      rstn_o
);

  // ************************************************************
  // Two flip-flop release chain
  // ************************************************************
  logic stage1;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage1 <= 1'b0;
      rstn_o <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      rstn_o <= stage1;
    end
  end

endmodule : eppr_rst_sync
`default_nettype wire

// ---- rtl/eppr_desc_check.sv ----
// Consistency check of a security info descriptor copy.
// Assumes the whole descriptor arrives as one word.
`timescale 1ns/1ps
`default_nettype none
module eppr_desc_check
  import eppr_pkg::*;
(
  input  wire logic [DESC_W-1:0] desc_i,
  output logic                   bad_o,
  output logic [RWX_W-1:0]       rwx_o
);

  // ************************************************************
  // Reserved fields and the write without read case
  // ************************************************************
  logic rsvd_set;

  assign rsvd_set = |desc_i[DESC_W-1:DESC_RSVD_LSB];
  assign rwx_o    = {desc_i[FLAG_X_POS], desc_i[FLAG_W_POS], desc_i[FLAG_R_POS]};
  assign bad_o    = rsvd_set || (!desc_i[FLAG_R_POS] && desc_i[FLAG_W_POS]);

endmodule : eppr_desc_check
`default_nettype wire

// ---- rtl/eppr_top.sv ----
// Sequencer of the restrict permission leaf for one protected page.
// Assumes synchronous memory and metadata responses on the core clock.
//
// What this block does
// - Descriptor address not 64-byte aligned faults
// - Page address not 4K aligned faults
// - Page outside protected cache gives page fault
// - Reserved descriptor bits or W without R fault
// - Other leaf accessing base gives protection fault
// - Invalid metadata entry gives page fault
// - Busy second-generation leaf returns conflict code
// - Pending or modified page returns not-modifiable code
// - Non-regular page type gives page fault
// - Uninitialized owner structure gives protection fault
// - Set restriction bit before permission update
// - New rights are old rights AND mask
// - Success clears zero flag, result zero
// - Every non-faulting completion clears arithmetic flags
// - Shared base access, base conflict faults
// - Exclusive against modify leaves, concurrent otherwise
// - Descriptor read non-enclave, page enclave read/write
// - Runs only at privilege level zero
`timescale 1ns/1ps
`default_nettype none
module eppr_top
  import eppr_pkg::*;
#(
  parameter int ADDR_W = 64
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  start_i,
  input  wire logic [LEAF_W-1:0]     leaf_code_i,
  input  wire logic [CPL_W-1:0]      cpl_i,
  input  wire logic [ADDR_W-1:0]     desc_addr_i,
  input  wire logic [ADDR_W-1:0]     page_addr_i,
  input  wire logic                  epc_hit_i,
  input  wire logic                  base_conflict_i,
  input  wire logic [LEAF_VEC_W-1:0] page_leaf_busy_i,
  input  wire logic                  desc_rsp_i,
  input  wire logic [DESC_W-1:0]     desc_data_i,
  input  wire logic                  meta_rsp_i,
  input  wire logic                  meta_entry_valid_i,
  input  wire logic                  meta_pending_i,
  input  wire logic                  meta_modified_i,
  input  wire logic [PAGE_TYPE_W-1:0] meta_type_i,
  input  wire logic [RWX_W-1:0]      meta_rwx_i,
  input  wire logic                  owner_rsp_i,
  input  wire logic                  owner_init_i,
  output logic                       busy_o,
  output logic                       desc_rd_req_o,
  output logic [ADDR_W-1:0]          desc_rd_addr_o,
  output logic                       desc_rd_nonenclave_o,
  output logic                       meta_rd_req_o,
  output logic [ADDR_W-1:0]          page_addr_o,
  output logic                       page_enclave_rw_o,
  output logic                       owner_rd_req_o,
  output logic                       meta_wr_pr_o,
  output logic                       meta_wr_rwx_o,
  output logic [RWX_W-1:0]           meta_wr_rwx_val_o,
  output logic                       done_o,
  output logic                       gp_fault_o,
  output logic                       page_fault_o,
  output logic [ADDR_W-1:0]          fault_addr_o,
  output logic [RESULT_W-1:0]        result_o,
  output logic                       zf_o,
  output logic                       cf_o,
  output logic                       pf_o,
  output logic                       af_o,
  output logic                       of_o,
  output logic                       sf_o
);

  // ************************************************************
  // Reset and helpers
  // ************************************************************
  logic rst_n;

  eppr_rst_sync u_rst_sync (
    .clk_i  (core_clk_i),
    .rstn_i (rstn_i),
    .rstn_o (rst_n)
  );

  function automatic logic is_aligned(input logic [ADDR_W-1:0] addr, input int bits);
    logic [ADDR_W-1:0] mask;
    mask = (ADDR_W'(1) << bits) - ADDR_W'(1);
    return (addr & mask) == '0;
  endfunction : is_aligned

  logic             desc_bad;
  logic [RWX_W-1:0] desc_rwx;

  eppr_desc_check u_desc_check (
    .desc_i (desc_data_i),
    .bad_o  (desc_bad),
    .rwx_o  (desc_rwx)
  );

  // ************************************************************
  // Check sequencing
  // ************************************************************
  eppr_state_t   state;
  eppr_state_t   next_state;
  eppr_outcome_t next_outcome;
  logic          next_desc_req;
  logic          next_meta_req;
  logic          next_owner_req;
  logic          next_wr_pr;
  logic          next_wr_rwx;
  logic          take;
  logic          excl_busy;
  logic [RWX_W-1:0] mask_rwx;
  logic [RWX_W-1:0] cur_rwx;

  assign take      = start_i && (leaf_code_i == RESTRICT_LEAF_CODE);
  assign excl_busy = |(page_leaf_busy_i & EXCLUSIVE_LEAF_MASK);

  always_comb begin
    next_state     = state;
    next_outcome   = OUT_NONE;
    next_desc_req  = 1'b0;
    next_meta_req  = 1'b0;
    next_owner_req = 1'b0;
    next_wr_pr     = 1'b0;
    next_wr_rwx    = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          if (cpl_i != KERNEL_CPL) begin
            next_outcome = OUT_GP;
          end else if (!is_aligned(desc_addr_i, DESC_ALIGN_BITS)) begin
            next_outcome = OUT_GP;
          end else if (!is_aligned(page_addr_i, PAGE_ALIGN_BITS)) begin
            next_outcome = OUT_GP;
          end else if (!epc_hit_i) begin
            next_outcome = OUT_PF;
          end else begin
            next_desc_req = 1'b1;
            next_state    = ST_DESC;
          end
        end
      end
      ST_DESC: begin
        if (desc_rsp_i) begin
          if (desc_bad) begin
            next_outcome = OUT_GP;
            next_state   = ST_IDLE;
          end else if (base_conflict_i) begin
            next_outcome = OUT_GP;
            next_state   = ST_IDLE;
          end else begin
            next_meta_req = 1'b1;
            next_state    = ST_META;
          end
        end
      end
      ST_META: begin
        if (meta_rsp_i) begin
          next_state = ST_IDLE;
          if (!meta_entry_valid_i) begin
            next_outcome = OUT_PF;
          end else if (excl_busy) begin
            next_outcome = OUT_CONFLICT;
          end else if (meta_pending_i || meta_modified_i) begin
            next_outcome = OUT_NOTMOD;
          end else if (meta_type_i != REGULAR_PAGE_TYPE) begin
            next_outcome = OUT_PF;
          end else begin
            next_owner_req = 1'b1;
            next_state     = ST_OWNER;
          end
        end
      end
      ST_OWNER: begin
        if (owner_rsp_i) begin
          if (!owner_init_i) begin
            next_outcome = OUT_GP;
            next_state   = ST_IDLE;
          end else begin
            next_wr_pr = 1'b1;
            next_state = ST_MARK;
          end
        end
      end
      ST_MARK: begin
        next_wr_rwx = 1'b1;
        next_state  = ST_UPDATE;
      end
      ST_UPDATE: begin
        next_outcome = OUT_OK;
        next_state   = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Memory and metadata requests
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      desc_rd_req_o        <= 1'b0;
      meta_rd_req_o        <= 1'b0;
      owner_rd_req_o       <= 1'b0;
      meta_wr_pr_o         <= 1'b0;
      meta_wr_rwx_o        <= 1'b0;
      desc_rd_nonenclave_o <= 1'b0;
      page_enclave_rw_o    <= 1'b0;
    end else begin
      desc_rd_req_o        <= next_desc_req;
      meta_rd_req_o        <= next_meta_req;
      owner_rd_req_o       <= next_owner_req;
      meta_wr_pr_o         <= next_wr_pr;
      meta_wr_rwx_o        <= next_wr_rwx;
      desc_rd_nonenclave_o <= next_desc_req;
      page_enclave_rw_o    <= next_meta_req || next_wr_pr || next_wr_rwx;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      desc_rd_addr_o <= '0;
      page_addr_o    <= '0;
    end else if ((state == ST_IDLE) && take) begin
      desc_rd_addr_o <= desc_addr_i;
      page_addr_o    <= page_addr_i;
    end
  end

  // ************************************************************
  // Scratch mask and permission merge
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_rwx <= '0;
    end else if ((state == ST_DESC) && desc_rsp_i) begin
      mask_rwx <= desc_rwx;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur_rwx <= '0;
    end else if ((state == ST_META) && meta_rsp_i) begin
      cur_rwx <= meta_rwx_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      meta_wr_rwx_val_o <= '0;
    end else if (next_wr_rwx) begin
      meta_wr_rwx_val_o <= cur_rwx & mask_rwx;
    end
  end

  // ************************************************************
  // Completion, faults, result and flags
  // ************************************************************
  logic next_finish;
  logic next_report;

  assign next_finish = (next_outcome != OUT_NONE);
  assign next_report = (next_outcome == OUT_OK) || (next_outcome == OUT_CONFLICT) ||
                       (next_outcome == OUT_NOTMOD);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      done_o       <= 1'b0;
      gp_fault_o   <= 1'b0;
      page_fault_o <= 1'b0;
    end else begin
      done_o       <= next_finish;
      gp_fault_o   <= (next_outcome == OUT_GP);
      page_fault_o <= (next_outcome == OUT_PF);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (next_state != ST_IDLE);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_addr_o <= '0;
    end else if (next_outcome == OUT_PF) begin
      fault_addr_o <= (state == ST_IDLE) ? page_addr_i : page_addr_o;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      result_o <= RESULT_OK;
      zf_o     <= 1'b0;
    end else if (next_report) begin
      unique case (next_outcome)
        OUT_CONFLICT: begin
          result_o <= PAGE_CONFLICT_CODE;
          zf_o     <= 1'b1;
        end
        OUT_NOTMOD: begin
          result_o <= PAGE_NOT_MODIFIABLE_CODE;
          zf_o     <= 1'b1;
        end
        default: begin
          result_o <= RESULT_OK;
          zf_o     <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cf_o <= 1'b0;
      pf_o <= 1'b0;
      af_o <= 1'b0;
      of_o <= 1'b0;
      sf_o <= 1'b0;
    end else if (next_report) begin
      cf_o <= 1'b0;
      pf_o <= 1'b0;
      af_o <= 1'b0;
      of_o <= 1'b0;
      sf_o <= 1'b0;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic idle_take;

  assign idle_take = (state == ST_IDLE) && take && (cpl_i == KERNEL_CPL);

  chk_desc_align: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    idle_take && !is_aligned(desc_addr_i, DESC_ALIGN_BITS)
      |=> done_o && gp_fault_o && !desc_rd_req_o)
    else $error("misaligned descriptor did not fault");

  chk_page_align: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    idle_take && is_aligned(desc_addr_i, DESC_ALIGN_BITS)
      && !is_aligned(page_addr_i, PAGE_ALIGN_BITS)
      |=> done_o && gp_fault_o)
    else $error("misaligned page did not fault");

  chk_epc_miss: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    idle_take && is_aligned(desc_addr_i, DESC_ALIGN_BITS)
      && is_aligned(page_addr_i, PAGE_ALIGN_BITS) && !epc_hit_i
      |=> done_o && page_fault_o && (fault_addr_o == $past(page_addr_i)))
    else $error("non-resident page did not page fault");

  chk_desc_bad: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (state == ST_DESC) && desc_rsp_i && desc_bad |=> gp_fault_o && !meta_rd_req_o)
    else $error("bad descriptor did not fault");

  chk_meta_invalid: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (state == ST_META) && meta_rsp_i && !meta_entry_valid_i |=> page_fault_o && done_o)
    else $error("invalid entry did not page fault");

  chk_conflict_code: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (state == ST_META) && meta_rsp_i && meta_entry_valid_i && excl_busy
      |=> done_o && zf_o && (result_o == PAGE_CONFLICT_CODE) && !owner_rd_req_o)
    else $error("page conflict not reported");

  chk_notmod_code: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (state == ST_META) && meta_rsp_i && meta_entry_valid_i && !excl_busy
      && (meta_pending_i || meta_modified_i)
      |=> zf_o && (result_o == PAGE_NOT_MODIFIABLE_CODE) ##1 !meta_wr_pr_o)
    else $error("not modifiable page not reported");

  chk_mark_first: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    meta_wr_pr_o |=> meta_wr_rwx_o ##1 done_o && !zf_o && (result_o == RESULT_OK))
    else $error("restriction mark not followed by update and success");

  chk_rights_and: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    meta_wr_rwx_o |-> $past(meta_wr_pr_o)
      && ((meta_wr_rwx_val_o & ~cur_rwx) == '0) && ((meta_wr_rwx_val_o & ~mask_rwx) == '0))
    else $error("rights update not masked or not preceded by mark");

  chk_flags_clear: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    done_o && !gp_fault_o && !page_fault_o |-> !(cf_o || pf_o || af_o || of_o || sf_o))
    else $error("arithmetic flags not cleared");

endmodule : eppr_top
`default_nettype wire

// ---- tb/eppr_tb_pkg.sv ----
// Row type of the permission restriction bench table.
// Assumes eppr_pkg is compiled first.
package eppr_tb_pkg;
  // ****************
  // Bench row
  // ****************
  typedef struct packed {
    logic [2:0] k;
    logic [2:0] er;
    logic [1:0] cpl;
    logic [1:0] mis;
    logic       epc;
    logic [2:0] msk;
    logic       rsv;
    logic       bc;
    logic       v;
    logic [1:0] pm;
    logic [7:0] ty;
    logic [2:0] rwx;
    logic       ini;
  } eppr_row_t;
endpackage : eppr_tb_pkg

// ---- tb/eppr_mem_model.sv ----
// Memory and metadata responder for the permission restriction engine.
// Assumes one request at a time; answers after dly_i + 1 idle cycles.
`timescale 1ns/1ps
`default_nettype none
module eppr_mem_model import eppr_pkg::*, eppr_tb_pkg::*; (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire eppr_row_t   row_i,
  input  wire logic [8:0]  busy_vec_i,
  input  wire logic [3:0]  dly_i,
  input  wire logic        desc_rd_req_i,
  input  wire logic        meta_rd_req_i,
  input  wire logic        owner_rd_req_i,
  output logic             desc_rsp_o,
  output logic [DESC_W-1:0] desc_data_o,
  output logic             base_conflict_o,
  output logic             meta_rsp_o,
  output logic             meta_valid_o,
  output logic             meta_pending_o,
  output logic             meta_modified_o,
  output logic [7:0]       meta_type_o,
  output logic [2:0]       meta_rwx_o,
  output logic [8:0]       page_leaf_busy_o,
  output logic             owner_rsp_o,
  output logic             owner_init_o
);
  logic [DESC_W-1:0] dword;
  logic [22:0]       mword;
  logic [1:0]        kind;
  logic [3:0]        cnt;
  logic              pend;
  // ****************
  // Answer data, inverted while no answer stands
  // ****************
  assign dword = {{(DESC_W-17){1'b0}}, row_i.rsv, 13'h0000, row_i.msk};
  assign mword = {row_i.v, row_i.pm, row_i.ty, row_i.rwx, busy_vec_i};
  assign desc_data_o = desc_rsp_o ? dword : ~dword;
  assign base_conflict_o = desc_rsp_o ? row_i.bc : ~row_i.bc;
  assign {meta_valid_o, meta_pending_o, meta_modified_o, meta_type_o, meta_rwx_o,
          page_leaf_busy_o} = meta_rsp_o ? mword : ~mword;
  assign owner_init_o = owner_rsp_o ? row_i.ini : ~row_i.ini;
  // ****************
  // Delayed answer pulses
  // ****************
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend        <= 1'b0;
      cnt         <= 4'h0;
      kind        <= 2'h0;
      desc_rsp_o  <= 1'b0;
      meta_rsp_o  <= 1'b0;
      owner_rsp_o <= 1'b0;
    end else begin
      desc_rsp_o  <= 1'b0;
      meta_rsp_o  <= 1'b0;
      owner_rsp_o <= 1'b0;
      if (desc_rd_req_i || meta_rd_req_i || owner_rd_req_i) begin
        pend <= 1'b1;
        cnt  <= dly_i;
        kind <= meta_rd_req_i ? 2'h1 : (owner_rd_req_i ? 2'h2 : 2'h0);
      end else if (pend && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pend) begin
        pend        <= 1'b0;
        desc_rsp_o  <= (kind == 2'h0);
        meta_rsp_o  <= (kind == 2'h1);
        owner_rsp_o <= (kind == 2'h2);
      end
    end
  end
endmodule : eppr_mem_model
`default_nettype wire

// ---- tb/test_eppr_top.sv ----
// Self-checking bench of the permission restriction engine.
// Assumes eppr_mem_model answers all memory and metadata reads.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_eppr_top import eppr_pkg::*, eppr_tb_pkg::*;;
  logic clk, rstn, start, epc, busy, dreq, dnon, mreq, oreq, wpr, wrwx, done, gp, pfa, encl, zf;
  logic drsp, bc, mrsp, mv, mp, mm, orsp, oi, saw_pr;
  logic [31:0] leaf;
  logic [1:0] cpl;
  logic [63:0] daddr, paddr, daddr_o, faddr, res, last_res, pao;
  logic [2:0] rwxv, mr, got;
  logic [4:0] fl;
  logic [DESC_W-1:0] dd;
  logic [7:0] mt;
  logic [8:0] bz, pb;
  logic [3:0] dly;
  eppr_row_t cur;
  eppr_row_t rows [17];
  eppr_row_t r;
  int fails, cmp_count, cyc, i;
  eppr_top eppr_top_i (.core_clk_i(clk), .rstn_i(rstn), .start_i(start), .leaf_code_i(leaf),
    .cpl_i(cpl), .desc_addr_i(daddr), .page_addr_i(paddr), .epc_hit_i(epc),
    .base_conflict_i(bc), .page_leaf_busy_i(pb), .desc_rsp_i(drsp), .desc_data_i(dd),
    .meta_rsp_i(mrsp), .meta_entry_valid_i(mv), .meta_pending_i(mp), .meta_modified_i(mm),
    .meta_type_i(mt), .meta_rwx_i(mr), .owner_rsp_i(orsp), .owner_init_i(oi), .busy_o(busy),
    .desc_rd_req_o(dreq), .desc_rd_addr_o(daddr_o), .desc_rd_nonenclave_o(dnon),
    .meta_rd_req_o(mreq), .page_addr_o(pao), .page_enclave_rw_o(encl), .owner_rd_req_o(oreq),
    .meta_wr_pr_o(wpr), .meta_wr_rwx_o(wrwx), .meta_wr_rwx_val_o(rwxv), .done_o(done),
    .gp_fault_o(gp), .page_fault_o(pfa), .fault_addr_o(faddr), .result_o(res), .zf_o(zf),
    .cf_o(fl[4]), .pf_o(fl[3]), .af_o(fl[2]), .of_o(fl[1]), .sf_o(fl[0]));
  eppr_mem_model eppr_mem_model_i (.core_clk_i(clk), .rstn_i(rstn), .row_i(cur),
    .busy_vec_i(bz), .dly_i(dly), .desc_rd_req_i(dreq), .meta_rd_req_i(mreq),
    .owner_rd_req_i(oreq), .desc_rsp_o(drsp), .desc_data_o(dd), .base_conflict_o(bc),
    .meta_rsp_o(mrsp), .meta_valid_o(mv), .meta_pending_o(mp), .meta_modified_o(mm),
    .meta_type_o(mt), .meta_rwx_o(mr), .page_leaf_busy_o(pb), .owner_rsp_o(orsp),
    .owner_init_o(oi));
  // ****************
  // Clock, watchdog and bus monitor
  // ****************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (dreq) `CHK({dnon, daddr_o}, {1'b1, daddr})
    if (mreq) `CHK(pao, paddr)
    if (mreq || wpr || wrwx) `CHK(encl, 1'b1)
    if (wpr) saw_pr = 1'b1;
    if (wrwx) begin
      `CHK(saw_pr, 1'b1)
      got = rwxv;
    end
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // ****************
  // One leaf run from a table row
  // ****************
  task automatic run(input eppr_row_t t, input logic [8:0] b, input logic [3:0] d);
    logic [63:0] exp;
    @(posedge clk);
    cur <= t;
    bz <= b;
    dly <= d;
    cpl <= t.cpl;
    epc <= t.epc;
    daddr <= 64'h0000_0000_0001_0040 + (t.mis[0] ? 64'h20 : 64'h0);
    paddr <= 64'h0000_0000_0020_3000 + (t.mis[1] ? 64'h800 : 64'h0);
    leaf <= RESTRICT_LEAF_CODE;
    start <= 1'b1;
    saw_pr = 1'b0;
    got = 3'h0;
    @(posedge clk);
    start <= 1'b0;
    while (done !== 1'b1) @(posedge clk);
    `CHK({gp, pfa}, {t.k == 3'h1, t.k == 3'h2})
    `CHK(saw_pr, t.k == 3'h0)
    if (t.k == 3'h2) `CHK(faddr, paddr)
    if (t.k == 3'h1 || t.k == 3'h2) `CHK(res, last_res)
    else begin
      exp = (t.k == 3'h3) ? PAGE_CONFLICT_CODE :
            ((t.k == 3'h4) ? PAGE_NOT_MODIFIABLE_CODE : RESULT_OK);
      `CHK(res, exp)
      `CHK(zf, t.k != 3'h0)
      `CHK(fl, 5'h00)
      last_res = exp;
    end
    if (t.k == 3'h0) `CHK(got, t.er)
    `CHK(busy, 1'b0)
  endtask : run
  // ****************
  // Main sequence
  // ****************
  initial begin
    {start, epc, cpl, leaf, daddr, paddr, bz, dly, saw_pr, got} = '0;
    rstn = 1'b0;
    fails = 0;
    cmp_count = 0;
    cyc = 0;
    last_res = RESULT_OK;
    rows[0]  = '{3'h0, 3'h5, 2'h0, 2'h0, 1'h1, 3'h5, 1'h0, 1'h0, 1'h1, 2'h0, 8'h01, 3'h7, 1'h1};
    rows[1]  = '{3'h0, 3'h2, 2'h0, 2'h0, 1'h1, 3'h3, 1'h0, 1'h0, 1'h1, 2'h0, 8'h01, 3'h6, 1'h1};
    rows[2]  = '{3'h1, 3'h0, 2'h3, 2'h0, 1'h1, 3'h5, 1'h0, 1'h0, 1'h1, 2'h0, 8'h01, 3'h7, 1'h1};
    rows[3]  = '{3'h1, 3'h0, 2'h0, 2'h1, 1'h1, 3'h5, 1'h0, 1'h0, 1'h1, 2'h0, 8'h01, 3'h7, 1'h1};
    rows[4]  = '{3'h1, 3'h0, 2'h0, 2'h2, 1'h1, 3'h5, 1'h0, 1'h0, 1'h1, 2'h0, 8'h01, 3'h7, 1'h1};
    rows[5]  = '{3'h2, 3'h0, 2'h0, 2'h0, 1'h0, 3'h5, 1'h0, 1'h0, 1'h1, 2'h0, 8'h01, 3'h7, 1'h1};
    rows[6]  = '{3'h1, 3'h0, 2'h0, 2'h0, 1'h1, 3'h5, 1'h1, 1'h0, 1'h1, 2'h0, 8'h01, 3'h7, 1'h1};
    rows[7]  = '{3'h1, 3'h0, 2'h0, 2'h0, 1'h1, 3'h2, 1'h0, 1'h0, 1'h1, 2'h0, 8'h01, 3'h7, 1'h1};
    rows[8]  = '{3'h1, 3'h0, 2'h0, 2'h0, 1'h1, 3'h5, 1'h0, 1'h1, 1'h1, 2'h0, 8'h01, 3'h7, 1'h1};
    rows[9]  = '{3'h2, 3'h0, 2'h0, 2'h0, 1'h1, 3'h5, 1'h0, 1'h0, 1'h0, 2'h0, 8'h01, 3'h7, 1'h1};
    rows[10] = '{3'h4, 3'h0, 2'h0, 2'h0, 1'h1, 3'h5, 1'h0, 1'h0, 1'h1, 2'h2, 8'h01, 3'h7, 1'h1};
    rows[11] = '{3'h4, 3'h0, 2'h0, 2'h0, 1'h1, 3'h5, 1'h0, 1'h0, 1'h1, 2'h1, 8'h01, 3'h7, 1'h1};
    rows[12] = '{3'h2, 3'h0, 2'h0, 2'h0, 1'h1, 3'h5, 1'h0, 1'h0, 1'h1, 2'h0, 8'h02, 3'h7, 1'h1};
    rows[13] = '{3'h1, 3'h0, 2'h0, 2'h0, 1'h1, 3'h5, 1'h0, 1'h0, 1'h1, 2'h0, 8'h01, 3'h7, 1'h0};
    rows[14] = '{3'h4, 3'h0, 2'h0, 2'h0, 1'h1, 3'h5, 1'h0, 1'h0, 1'h1, 2'h1, 8'h00, 3'h7, 1'h1};
    rows[15] = '{3'h2, 3'h0, 2'h0, 2'h0, 1'h1, 3'h5, 1'h0, 1'h0, 1'h0, 2'h0, 8'h01, 3'h7, 1'h0};
    rows[16] = '{3'h1, 3'h0, 2'h0, 2'h0, 1'h1, 3'h5, 1'h0, 1'h1, 1'h0, 2'h0, 8'h01, 3'h7, 1'h1};
    cur = rows[0];
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    for (i = 0; i < 17; i++) run(rows[i], 9'h000, i[0] ? 4'h3 : 4'h0);
    for (i = 0; i < 9; i++) begin
      r = rows[10];
      r.k = (i < 5) ? 3'h3 : 3'h4;
      run(r, 9'h001 << i, 4'h1);
    end
    @(posedge clk);
    leaf <= 32'h0000_000F;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(busy, 1'b0)
    cur <= rows[0];
    dly <= 4'hF;
    leaf <= RESTRICT_LEAF_CODE;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(busy, 1'b1)
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({busy, done, zf, res}, {3'h0, RESULT_OK})
    rstn <= 1'b1;
    last_res = RESULT_OK;
    repeat (5) @(posedge clk);
    run(rows[1], 9'h000, 4'h0);
    finish_test();
  end
endmodule : test_eppr_top
`default_nettype wire
